// [interval_timer.v]
/*
 * Sixteen-bit interval timer with period match, prescaler, gated accumulation
 * and idle/sleep behaviour, reached over an AXI4-Lite slave.
 * Assumes one clock; the external pin passes a synchroniser except on the asynchronous path, and the cpu state is set by software over the bus.
 */
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_defs.vh"

module interval_timer (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  // AXI4-Lite write address and data
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // External pin and interrupt
  input  wire        ext_clock_gate_i,
  output wire        irq_o
);

  // ============================================================
  // Registers
  reg  [15:0] count_q;
  reg  [15:0] period_q;
  reg  [15:0] control_q;
  reg  [1:0]  irq_status_q;
  reg  [1:0]  irq_enable_q;
  reg  [1:0]  cpu_state_q;
  reg  [4:0]  awaddr_q;
  reg         aw_held_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_held_q;
  reg         sync1_q;
  reg         sync2_q;
  reg         pin_prev_q;
  reg         async_prev_q;

  // Reserved control bits are masked on write, so they always read as zero.
  wire count_enable_bit      = control_q[`CTL_ENABLE_BIT];
  wire idle_stop_bit         = control_q[`CTL_IDLE_STOP];
  wire gate_accum_enable     = control_q[`CTL_GATE_ACCUM];
  wire [1:0] prescale_select = control_q[`CTL_PRESC_HI:`CTL_PRESC_LO];
  wire external_sync_select  = control_q[`CTL_SYNC_SEL];
  wire clock_source_select   = control_q[`CTL_CLK_SRC];
  wire cpu_idle              = cpu_state_q[`CPU_IDLE_BIT];
  wire cpu_sleep             = cpu_state_q[`CPU_SLEEP_BIT];

  // ============================================================
  // AXI4-Lite write channel: address and data taken in either order.
  // Each half is parked in its own holding register, so a master that offers
  // data before the address is never stalled waiting for the other channel.
  // A write only takes effect once no response is pending; this keeps a second
  // write from overtaking the response of the first.
  wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_addr_ok = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `OFS_CPU_STATE);
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 5'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_addr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lanes 0 and 1 carry register bits; lanes 2 and 3 are ignored.
  // An unmapped address selects no register, so its write has no effect.
  wire [15:0] wmask  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_count   = wr_fire && awaddr_q == {1'b0, `OFS_COUNT};
  wire wr_period  = wr_fire && awaddr_q == {1'b0, `OFS_PERIOD};
  wire wr_control = wr_fire && awaddr_q == {1'b0, `OFS_CONTROL};
  wire wr_irq_clr = wr_fire && awaddr_q == `OFS_IRQ_CLEAR;
  wire wr_irq_en  = wr_fire && awaddr_q == `OFS_IRQ_ENABLE;
  wire wr_cpu     = wr_fire && awaddr_q == `OFS_CPU_STATE;

  // ============================================================
  // AXI4-Lite read channel: answer one cycle after the address is taken.
  // The read data is a snapshot taken at the accepting edge; a count that moves
  // on while rvalid waits for rready is not reflected in the answer.
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        {1'b0, `OFS_COUNT}:   s_axi_rdata <= {16'h0000, count_q};
        {1'b0, `OFS_PERIOD}:  s_axi_rdata <= {16'h0000, period_q};
        {1'b0, `OFS_CONTROL}: s_axi_rdata <= {16'h0000, control_q};
        {1'b0, `OFS_IRQ_STATUS}: s_axi_rdata <= {30'h0, irq_status_q};
        `OFS_IRQ_CLEAR:       s_axi_rdata <= 32'h00000000;
        `OFS_IRQ_ENABLE:      s_axi_rdata <= {30'h0, irq_enable_q};
        `OFS_CPU_STATE:       s_axi_rdata <= {30'h0, cpu_state_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // Pin edge detection.
  // The synchronous path uses two flops; the asynchronous path looks at the
  // raw pin so it keeps counting in sleep when the synchroniser is bypassed.
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sync1_q      <= 1'b0;
      sync2_q      <= 1'b0;
      pin_prev_q   <= 1'b0;
      async_prev_q <= 1'b0;
    end else begin
      sync1_q      <= ext_clock_gate_i;
      sync2_q      <= sync1_q;
      pin_prev_q   <= sync2_q;
      async_prev_q <= ext_clock_gate_i;
    end
  end

  wire sync_rise  = sync2_q && !pin_prev_q;
  wire async_rise = ext_clock_gate_i && !async_prev_q;
  // The gate falling edge is taken from the synchronised pin, so that it lines
  // up with the last cycle that the gated count accumulated.
  wire gate_fall  = !sync2_q && pin_prev_q;

  // ============================================================
  // Tick source selection and idle/sleep gating.
  // In gated accumulation the synchronised pin level is itself the tick, so
  // one cycle is accumulated for every cycle that the gate stays high.
  // The gate is not edge counted, which lets the prescaler divide it as well.
  reg raw_tick;
  always @* begin
    if (clock_source_select)
      raw_tick = external_sync_select ? sync_rise : async_rise;
    else if (gate_accum_enable)
      raw_tick = sync2_q;
    else
      raw_tick = 1'b1;
  end

  // Sleep stops every tick source except the unsynchronised pin, the only one
  // whose edges do not rely on the stopped internal phase clocks.
  // Idle with the stop bit set pauses every source alike.
  wire async_ext = clock_source_select && !external_sync_select;
  wire stalled   = (cpu_idle && idle_stop_bit) ||
                   (cpu_sleep && !async_ext);
  wire base_tick = raw_tick && !stalled;

  wire presc_tick;
  // Any count write and any control write that drops the enable clear the
  // prescaler; while halted it ignores both, as it has no clock to act on.
  wire presc_clear = wr_count || (wr_control && wmask[15] && !wdata_q[`CTL_ENABLE_BIT]);

  // The prescaler sees the tick after idle and sleep gating, so a stalled
  // timer also keeps its prescale phase until it resumes.
  timer_prescaler u_presc (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .run_i     (count_enable_bit),
    .clear_i   (presc_clear),
    .select_i  (prescale_select),
    .tick_i    (base_tick),
    .tick_o    (presc_tick)
  );

  // ============================================================
  // Count, period and control registers.
  // The match is judged on the tick itself: the count shows the period value
  // for a full prescaled interval and returns to zero on the following tick.
  // A period below the current count lets the count run on to its wrap.
  wire match_evt = count_enable_bit && presc_tick && (count_q == period_q);
  wire gate_evt  = count_enable_bit && gate_accum_enable && !clock_source_select && gate_fall;
  wire count_tick = count_enable_bit && presc_tick;
  reg  [15:0] count_d;

  // A count write wins over a tick in the same cycle, so the value that
  // software wrote is loaded and not lost to that tick.
  always @* begin
    count_d = count_q;
    if (wr_count)
      count_d = (count_q & ~wmask) | (wdata_q[15:0] & wmask);
    else if (match_evt)
      count_d = 16'h0000;
    else if (count_tick)
      count_d = count_q + 16'h0001;
  end

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      count_q     <= `RST_COUNT;
      period_q    <= `RST_PERIOD;
      control_q   <= `RST_CONTROL;
      cpu_state_q <= 2'h0;
    end else begin
      count_q <= count_d;
      if (wr_period)
        period_q <= (period_q & ~wmask) | (wdata_q[15:0] & wmask);
      if (wr_control)
        control_q <= (control_q & ~wmask) | (wdata_q[15:0] & wmask & `CTL_WRITE_MASK);
      // Idle and sleep reach this block only through software, as it has no
      // other view of the processor state.
      if (wr_cpu && wstrb_q[0])
        cpu_state_q <= wdata_q[1:0];
    end
  end

  // ============================================================
  // Interrupt status: events win over a clear in the same cycle.
  // Each status bit is sticky: only a one written to the clear register drops
  // it, so an event is never lost to a clear that races it.
  wire [1:0] irq_event = {gate_evt, match_evt};
  wire [1:0] irq_clear = (wr_irq_clr && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;
  wire [1:0] irq_status_d;

  genvar irq_idx;
  generate
    for (irq_idx = 0; irq_idx < 2; irq_idx = irq_idx + 1) begin : g_irq_bit
      assign irq_status_d[irq_idx] = irq_event[irq_idx] ||
                                     (irq_status_q[irq_idx] && !irq_clear[irq_idx]);
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_status_q <= 2'h0;
      irq_enable_q <= 2'h0;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_irq_en && wstrb_q[0])
        irq_enable_q <= wdata_q[1:0];
    end
  end

  // The request is a level: it stays up until software clears the status bit
  // or masks it, and a masked event still leaves its status bit set.
  assign irq_o = |(irq_status_q & irq_enable_q);

endmodule
`default_nettype wire

// [interval_timer_defs.vh]
/*
 * Constants for the 16-bit interval timer: register offsets, field positions,
 * reset values and prescale codes.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef INTERVAL_TIMER_DEFS_VH
`define INTERVAL_TIMER_DEFS_VH

// ============================================================
// Register byte offsets (AXI4-Lite, one word each)
`define OFS_COUNT        4'h0
`define OFS_PERIOD       4'h4
`define OFS_CONTROL      4'h8
`define OFS_IRQ_STATUS   4'hc
`define OFS_IRQ_CLEAR    5'h10
`define OFS_IRQ_ENABLE   5'h14
`define OFS_CPU_STATE    5'h18

// ============================================================
// Control register field positions
`define CTL_ENABLE_BIT   15
`define CTL_IDLE_STOP    13
`define CTL_GATE_ACCUM   6
`define CTL_PRESC_HI     5
`define CTL_PRESC_LO     4
`define CTL_SYNC_SEL     2
`define CTL_CLK_SRC      1
`define CTL_WRITE_MASK   16'ha076

// ============================================================
// Status bits and cpu state bits
`define IRQ_MATCH_BIT    0
`define IRQ_GATE_BIT     1
`define CPU_IDLE_BIT     0
`define CPU_SLEEP_BIT    1

// ============================================================
// Reset values
`define RST_COUNT        16'h0000
`define RST_PERIOD       16'hffff
`define RST_CONTROL      16'h0000

// ============================================================
// Prescale codes and terminal counts
`define PRESC_DIV1       2'h0
`define PRESC_DIV8       2'h1
`define PRESC_DIV64      2'h2
`define PRESC_DIV256     2'h3
`define PRESC_TC8        8'h07
`define PRESC_TC64       8'h3f
`define PRESC_TC256      8'hff

`endif

// [timer_prescaler.v]
/*
 * Prescaler for the interval timer: passes one tick out of 1, 8, 64 or 256.
 * Assumes tick_i is in the clk_sys_i domain; every cycle that it is high counts, so it may stay high.
 */
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_defs.vh"

module timer_prescaler (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  // Control
  input  wire       run_i,
  input  wire       clear_i,
  input  wire [1:0] select_i,
  input  wire       tick_i,
  // Divided tick
  output wire       tick_o
);

  reg  [7:0] count_q;
  reg  [7:0] count_d;
  reg  [7:0] term;

  always @* begin
    case (select_i)
      `PRESC_DIV8:   term = `PRESC_TC8;
      `PRESC_DIV64:  term = `PRESC_TC64;
      `PRESC_DIV256: term = `PRESC_TC256;
      default:       term = 8'h00;
    endcase
  end

  assign tick_o = run_i && tick_i && (count_q >= term);

  // The clear only acts while running: a halted prescaler has no clock to reset it.
  always @* begin
    count_d = count_q;
    if (run_i) begin
      if (clear_i)
        count_d = 8'h00;
      else if (tick_i)
        count_d = (count_q >= term) ? 8'h00 : count_q + 8'h01;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!resetn_i)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end

endmodule
`default_nettype wire

// [ext_pin_source.sv]
/* Model of the source that drives the timer's external clock and gate pin.
   Assumes go_i is a one-cycle request in the system clock domain. */
`timescale 1ns/10ps
`default_nettype none
module ext_pin_source (
  // Clock and requests
  input  wire logic       clk_sys_i,
  input  wire logic       go_i,
  input  wire logic [3:0] n_i,
  input  wire logic       gate_i,
  // Pin
  output var  logic       pin_o
);
  // ==========================================================
  // Pulse train
  // Four cycles high and four low, so the two-stage synchroniser never drops an edge.
  logic [3:0] left_q = 4'h0;
  logic [2:0] ph_q   = 3'h0;
  initial pin_o = 1'b0;
  always @(posedge clk_sys_i) begin
    if (go_i) begin
      left_q <= n_i;
      ph_q   <= 3'h0;
    end else if (left_q != 4'h0) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) left_q <= left_q - 4'h1;
    end
    pin_o <= gate_i | (left_q != 4'h0 && !go_i && ph_q < 3'h4);
  end
endmodule
`default_nettype wire

// [interval_timer_assertions.sv]
/* Checker for the interval timer's bus and interrupt ports.
   Assumes it is bound to interval_timer, one clock, reset active low. */
`timescale 1ns/10ps
`default_nettype none
module interval_timer_assertions (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Interrupt
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Bus answers
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");
  property p_read_release; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_read_release: assert property (p_read_release) else $error("read answer not released");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_refused_data; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
  endproperty
  a_refused_data: assert property (p_refused_data) else $error("refused read has data");
  // ==========================================================
  // Interrupt
  property p_irq_sticky; irq_o && s_axi_wready && !s_axi_wvalid |=> irq_o; endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq cleared by itself");
  property p_reset_quiet; $rose(resetn_i) |-> !irq_o && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_irq: cover property ($rose(irq_o));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind interval_timer interval_timer_assertions chk (.clk_sys_i, .resetn_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_o);
`default_nettype wire

// [tb.sv]
/* Self-checking bench for the interval timer over its register bus.
   Assumes ext_pin_source drives the external pin. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_sys_i = 0, resetn_i = 0, go = 0, gate = 0;
  logic [3:0]  npul = 0, s_axi_wstrb = 4'h3;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [1:0]  rr, br;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         irq_o, ext_clock_gate_i;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          failures = 0, total_checks = 0, n, dv[4] = '{1, 8, 64, 256};
  always #5 clk_sys_i = ~clk_sys_i;
  interval_timer uut (.clk_sys_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_gate_i, .irq_o);
  ext_pin_source src (.clk_sys_i, .go_i(go), .n_i(npul), .gate_i(gate),
    .pin_o(ext_clock_gate_i));
  // ==========================================================
  // Reporting
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rng(input logic [31:0] g, lo, hi);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, g, lo);
    end
  endtask
  task chk(input logic [31:0] g, e);
    rng(g, e, e);
  endtask
  task tmo(input int k, lim);
    if (k >= lim) begin
      rng(1, 0, 0);
      give_verdict;
    end
  endtask
  // ==========================================================
  // Bus and pin tasks
  task wrreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    br = s_axi_bresp;
    s_axi_bready <= 0;
    tmo(n, 50);
  endtask
  task rdreg(input logic [4:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(n, 50);
  endtask
  task rchk(input logic [4:0] a, input logic [31:0] e);
    rdreg(a);
    chk(rd, e);
  endtask
  task pulses(input logic [3:0] k);
    @(posedge clk_sys_i);
    go <= 1;
    npul <= k;
    @(posedge clk_sys_i);
    go <= 0;
    repeat (8 * k + 8) @(posedge clk_sys_i);
  endtask
  task idle(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    idle(3);
    resetn_i <= 1;
    rchk(5'h00, 0); rchk(5'h04, 32'hffff); rchk(5'h08, 0);
    rdreg(5'h1c); chk(rr, 2);
    wrreg(5'h02, 16'h0009); chk(br, 2); rchk(5'h00, 0);
    wrreg(5'h00, 16'h0005); chk(br, 0); idle(20); rchk(5'h00, 5);
    wrreg(5'h08, 16'h7fff); rchk(5'h08, 32'h2076); rchk(5'h00, 5);
    for (int k = 0; k < 4; k++) begin
      wrreg(5'h00, 0);
      wrreg(5'h08, 16'h8000 | (k << 4));
      idle(1024);
      wrreg(5'h08, 0);
      rdreg(5'h00); rng(rd, 1024 / dv[k] - 1, 1040 / dv[k]);
    end
    wrreg(5'h14, 1); wrreg(5'h04, 20); wrreg(5'h00, 0); wrreg(5'h08, 16'h8000);
    n = 0;
    while (irq_o !== 1'b1 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    tmo(n, 300);
    rng(n, 19, 21);
    wrreg(5'h08, 0); rdreg(5'h00); rng(rd, 0, 4);
    idle(30); rchk(5'h0c, 1);
    wrreg(5'h10, 1); rchk(5'h0c, 0); chk(irq_o, 0);
    wrreg(5'h04, 16'hffff); wrreg(5'h00, 0); wrreg(5'h18, 1);
    wrreg(5'h08, 16'ha000); idle(50); rchk(5'h00, 0);
    wrreg(5'h08, 16'h8000); idle(50); rdreg(5'h00); rng(rd, 50, 60);
    wrreg(5'h08, 0); wrreg(5'h00, 0); wrreg(5'h08, 16'ha002);
    pulses(4); rchk(5'h00, 0);
    wrreg(5'h18, 0); pulses(4); rchk(5'h00, 4);
    wrreg(5'h08, 0); wrreg(5'h00, 0); wrreg(5'h08, 16'h8006);
    pulses(5); rchk(5'h00, 5);
    wrreg(5'h18, 2); pulses(3); rchk(5'h00, 5);
    wrreg(5'h08, 16'h8002); pulses(3); rchk(5'h00, 8);
    wrreg(5'h08, 16'h8000); idle(30); rchk(5'h00, 8);
    wrreg(5'h18, 0); wrreg(5'h08, 0); wrreg(5'h00, 0); wrreg(5'h14, 2);
    wrreg(5'h08, 16'h8040); idle(10);
    gate <= 1;
    idle(40);
    gate <= 0;
    idle(10);
    rdreg(5'h00); rng(rd, 38, 42);
    chk(irq_o, 1); rchk(5'h0c, 2);
    give_verdict;
  end
endmodule
`default_nettype wire
